// ---- pbf_port_b_func_sel.sv ----
// module: function select registers and pin multiplexer of port b
`timescale 1ns/1ns
`default_nettype none

module pbf_port_b_func_sel (
	// clock and power-on reset
	input wire logic CLOCK_I,
	input wire logic ARST_N_I,
	// register port
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [15:0] WR_DATA_I,
	output logic [15:0] RD_DATA_O,
	// neighbouring direction and data registers
	input wire logic [15:0] DIR_I,
	input wire logic [15:0] GPIO_OUT_I,
	output logic [15:0] GPIO_IN_O,
	// pads
	input wire logic [15:0] PAD_I,
	output logic [15:0] PAD_O,
	output logic [15:0] PAD_OE_N_O,
	// peripheral outputs toward the pads
	input wire logic [15:0] PATTERN_I,
	input wire pbf_pkg::pbf_timer_out_type TIMER_OUT_I,
	input wire pbf_pkg::pbf_serial_out_type SERIAL_OUT_I,
	// peripheral inputs from the pads
	output logic [3:0] EXT_INT_REQ_O,
	output var pbf_pkg::pbf_timer_in_type TIMER_IN_O,
	output var pbf_pkg::pbf_serial_in_type SERIAL_IN_O
);

	logic [15:0] func_high; // pins 15..8, two bits each
	logic [15:0] func_low; // pins 7..0, two bits each
	logic [15:0] pad_meta; // first synchroniser stage
	logic [15:0] pad_sync; // second synchroniser stage
	wire [31:0] func_sel; // pin i mode at bits 2i+1:2i
	wire hit_high; // address selects upper register
	wire hit_low; // address selects lower register
	wire [15:0] next_rd; // read mux
	wire [15:0] alt2_out; // code 10 output per pin
	wire [15:0] is_alt1; // pin uses a valid code 01 function
	wire [15:0] is_alt2; // pin uses a valid code 10 function
	wire [15:0] is_pat; // pin shows the pattern output
	wire [15:0] is_gpio; // pin behaves as general i/o
	wire [15:0] next_pad; // next pad level
	wire [15:0] next_drive; // next pad drive enable, high drives
	wire [15:0] next_in1; // next code 01 peripheral inputs
	wire [15:0] next_in2; // next code 10 peripheral inputs

	// register decode
	assign hit_high = (ADDR_I == pbf_pkg::PBF_ADDR_HIGH);
	assign hit_low = (ADDR_I == pbf_pkg::PBF_ADDR_LOW);
	// upper register holds the top pins
	assign func_sel = {func_high, func_low};
	// read mux, unmapped offsets read zero
	assign next_rd = hit_high ? func_high : (hit_low ? func_low : pbf_pkg::PBF_READ_IDLE);

	// code 10 output sources, one bit per pin
	assign alt2_out[15] = 1'b0; // reserved
	assign alt2_out[14] = 1'b0; // reserved
	assign alt2_out[13] = SERIAL_OUT_I.clk1;
	assign alt2_out[12] = SERIAL_OUT_I.clk0;
	assign alt2_out[11] = SERIAL_OUT_I.tx1;
	assign alt2_out[10] = 1'b0;
	assign alt2_out[9] = SERIAL_OUT_I.tx0;
	assign alt2_out[8] = 1'b0;
	assign alt2_out[7] = TIMER_OUT_I.cmp_xb;
	assign alt2_out[6] = TIMER_OUT_I.cmp_xa;
	assign alt2_out[5] = TIMER_OUT_I.capcomp[5];
	assign alt2_out[4] = TIMER_OUT_I.capcomp[4];
	assign alt2_out[3] = TIMER_OUT_I.capcomp[3];
	assign alt2_out[2] = TIMER_OUT_I.capcomp[2];
	assign alt2_out[1] = TIMER_OUT_I.capcomp[1];
	assign alt2_out[0] = TIMER_OUT_I.capcomp[0];

	// per-pin mode decode and pad selection
	genvar i;
	generate
		for (i = 0; i < pbf_pkg::PBF_PINS; i = i + 1) begin : g_pin
			wire [1:0] pin_mode; // this pin's field
			assign pin_mode = func_sel[2*i+1:2*i];
			// reserved codes fall back to general i/o
			assign is_alt1[i] = (pin_mode == pbf_pkg::PBF_MODE_ALT1) && pbf_pkg::PBF_ALT1_VALID[i];
			assign is_alt2[i] = (pin_mode == pbf_pkg::PBF_MODE_ALT2) && pbf_pkg::PBF_ALT2_VALID[i];
			assign is_pat[i] = (pin_mode == pbf_pkg::PBF_MODE_PATTERN);
			assign is_gpio[i] = !is_alt1[i] && !is_alt2[i] && !is_pat[i];
			// pattern first, then code 10 source, else data register
			assign next_pad[i] = is_pat[i] ? PATTERN_I[i] : (is_alt2[i] ? alt2_out[i] : GPIO_OUT_I[i]);
			// drive: pattern always, code 10 per kind, gpio per direction
			assign next_drive[i] = is_pat[i]
				|| (is_alt2[i] && (pbf_pkg::PBF_ALT2_DRIVE[i] || (pbf_pkg::PBF_ALT2_DIR[i] && DIR_I[i])))
				|| (is_gpio[i] && DIR_I[i]);
			// peripheral inputs see the pad only while selected
			assign next_in1[i] = is_alt1[i] ? pad_sync[i] : pbf_pkg::PBF_IDLE_ALT1[i];
			assign next_in2[i] = is_alt2[i] ? pad_sync[i] : pbf_pkg::PBF_IDLE_ALT2[i];
		end
	endgenerate

	// function registers, cleared by power-on reset only
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			func_high <= pbf_pkg::PBF_RESET_VALUE;
			func_low <= pbf_pkg::PBF_RESET_VALUE;
		end else if (WR_I && hit_high) begin
			func_high <= WR_DATA_I;
		end else if (WR_I && hit_low) begin
			func_low <= WR_DATA_I;
		end
	end

	// read data stands one cycle after the strobe only
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			RD_DATA_O <= pbf_pkg::PBF_READ_IDLE;
		end else begin
			RD_DATA_O <= RD_I ? next_rd : pbf_pkg::PBF_READ_IDLE;
		end
	end

	// two-stage pad synchroniser
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			pad_meta <= 16'h0000;
			pad_sync <= 16'h0000;
		end else begin
			pad_meta <= PAD_I;
			pad_sync <= pad_meta;
		end
	end

	// registered pad side, enable low means driving
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PAD_O <= 16'h0000;
			PAD_OE_N_O <= 16'hffff;
		end else begin
			PAD_O <= next_pad;
			PAD_OE_N_O <= ~next_drive;
		end
	end

	// registered peripheral inputs and pin status
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			GPIO_IN_O <= 16'h0000;
			EXT_INT_REQ_O <= 4'hf;
			TIMER_IN_O <= '0;
			SERIAL_IN_O <= '0;
		end else begin
			GPIO_IN_O <= pad_sync;
			EXT_INT_REQ_O[3] <= next_in1[15];
			EXT_INT_REQ_O[2] <= next_in1[14];
			EXT_INT_REQ_O[1] <= next_in1[13];
			EXT_INT_REQ_O[0] <= next_in1[12];
			SERIAL_IN_O.clk1 <= next_in2[13];
			SERIAL_IN_O.clk0 <= next_in2[12];
			SERIAL_IN_O.rx1 <= next_in2[10];
			SERIAL_IN_O.rx0 <= next_in2[8];
			TIMER_IN_O.ext_clk_d <= next_in1[7];
			TIMER_IN_O.ext_clk_c <= next_in1[6];
			TIMER_IN_O.capcomp <= next_in2[5:0];
		end
	end

	// checks on the multiplexer, one cycle from mode to pad
	a_pin15_irq: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[31:30] == 2'b01) |=> (EXT_INT_REQ_O[3] == $past(pad_sync[15])) && PAD_OE_N_O[15])
		else $error("pin 15 irq path wrong");

	a_pin14_reserved: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[29:28] == 2'b10) |=> (PAD_OE_N_O[14] == !$past(DIR_I[14]))
		&& (PAD_O[14] == $past(GPIO_OUT_I[14])))
		else $error("pin 14 reserved code not gpio");

	a_pin13_sck_in: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[27:26] == 2'b10) |=> (SERIAL_IN_O.clk1 == $past(pad_sync[13])))
		else $error("pin 13 serial clock input wrong");

	a_pin12_pattern: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[25:24] == 2'b11) |=> (PAD_O[12] == $past(PATTERN_I[12])) && !PAD_OE_N_O[12])
		else $error("pin 12 pattern output wrong");

	a_pin11_tx: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[23:22] == 2'b10) |=> (PAD_O[11] == $past(SERIAL_OUT_I.tx1)) && !PAD_OE_N_O[11])
		else $error("pin 11 transmit output wrong");

	a_pin10_rx: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[21:20] == 2'b10) |=> PAD_OE_N_O[10] && (SERIAL_IN_O.rx1 == $past(pad_sync[10])))
		else $error("pin 10 receive input wrong");

	a_pin9_reserved: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[19:18] == 2'b01) |=> (PAD_OE_N_O[9] == !$past(DIR_I[9]))
		&& (PAD_O[9] == $past(GPIO_OUT_I[9])))
		else $error("pin 9 reserved code not gpio");

	a_pin8_rx: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[17:16] == 2'b10) |=> PAD_OE_N_O[8] && (SERIAL_IN_O.rx0 == $past(pad_sync[8])))
		else $error("pin 8 receive input wrong");

	a_pin7_tclk: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[15:14] == 2'b01) |=> PAD_OE_N_O[7] && (TIMER_IN_O.ext_clk_d == $past(pad_sync[7])))
		else $error("pin 7 timer clock input wrong");

	a_pin6_compare: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[13:12] == 2'b10) |=> (PAD_O[6] == $past(TIMER_OUT_I.cmp_xa)) && !PAD_OE_N_O[6])
		else $error("pin 6 compare output wrong");

	a_pin5_capcomp: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[11:10] == 2'b10) |=> (PAD_OE_N_O[5] == !$past(DIR_I[5]))
		&& (PAD_O[5] == $past(TIMER_OUT_I.capcomp[5])))
		else $error("pin 5 capture compare wrong");

	a_pin4_capture: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[9:8] == 2'b10) |=> (TIMER_IN_O.capcomp[4] == $past(pad_sync[4])))
		else $error("pin 4 capture input wrong");

	a_pin3_pattern: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[7:6] == 2'b11) |=> (PAD_O[3] == $past(PATTERN_I[3])) && !PAD_OE_N_O[3])
		else $error("pin 3 pattern output wrong");

	a_pin2_reserved: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[5:4] == 2'b01) |=> (PAD_OE_N_O[2] == !$past(DIR_I[2]))
		&& (TIMER_IN_O.capcomp[2] == 1'b0))
		else $error("pin 2 reserved code not gpio");

	a_pin1_capcomp: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[3:2] == 2'b10) && DIR_I[1] |=> !PAD_OE_N_O[1]
		&& (PAD_O[1] == $past(TIMER_OUT_I.capcomp[1])))
		else $error("pin 1 capture compare output wrong");

	a_pin0_capture: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[1:0] == 2'b10) && !DIR_I[0] |=> PAD_OE_N_O[0]
		&& (TIMER_IN_O.capcomp[0] == $past(pad_sync[0])))
		else $error("pin 0 capture input wrong");

	// write then read returns the written value
	a_write_read_back: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(WR_I && hit_high) ##1 (RD_I && hit_high) |=> (RD_DATA_O == $past(WR_DATA_I, 2)))
		else $error("upper register read back wrong");

	// a lower write leaves the upper pins alone
	a_low_no_high: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(WR_I && hit_low) |=> $stable(func_high) && (func_low == $past(WR_DATA_I)))
		else $error("lower write disturbed upper register");

	// without a write the settings hold
	a_hold_no_write: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		!WR_I |=> $stable(func_sel))
		else $error("function select changed without write");

	// gpio pin follows its direction bit
	// sampled reset gates the release edge, whose pads still hold reset values
	a_gpio_direction: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		ARST_N_I && (func_sel[21:20] == 2'b00) |=> (PAD_OE_N_O[10] == !$past(DIR_I[10]))
		&& (PAD_O[10] == $past(GPIO_OUT_I[10])))
		else $error("gpio pin direction wrong");

	// pins 15 to 12 as interrupt, serial clock or pattern pins
	a_pin15_pattern: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[31:30] == 2'b11) |=> (PAD_O[15] == $past(PATTERN_I[15])) && !PAD_OE_N_O[15])
		else $error("pin 15 pattern output wrong");

	a_pin15_reserved: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[31:30] == 2'b10) |=> (PAD_OE_N_O[15] == !$past(DIR_I[15]))
		&& (PAD_O[15] == $past(GPIO_OUT_I[15])))
		else $error("pin 15 reserved code not gpio");

	a_pin14_irq: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[29:28] == 2'b01) |=> (EXT_INT_REQ_O[2] == $past(pad_sync[14])) && PAD_OE_N_O[14])
		else $error("pin 14 interrupt path wrong");

	a_pin13_irq: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[27:26] == 2'b01) |=> (EXT_INT_REQ_O[1] == $past(pad_sync[13])) && PAD_OE_N_O[13])
		else $error("pin 13 interrupt path wrong");

	a_pin13_sck_out: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[27:26] == 2'b10) && DIR_I[13] |=> !PAD_OE_N_O[13]
		&& (PAD_O[13] == $past(SERIAL_OUT_I.clk1)))
		else $error("pin 13 serial clock output wrong");

	a_pin12_irq: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[25:24] == 2'b01) |=> (EXT_INT_REQ_O[0] == $past(pad_sync[12])) && PAD_OE_N_O[12])
		else $error("pin 12 interrupt path wrong");

	a_pin12_sck: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[25:24] == 2'b10) |=> (PAD_OE_N_O[12] == !$past(DIR_I[12]))
		&& (SERIAL_IN_O.clk0 == $past(pad_sync[12])))
		else $error("pin 12 serial clock wrong");

	// pins 11 to 6 as serial data, timer clock or compare pins
	a_pin11_reserved: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[23:22] == 2'b01) |=> (PAD_OE_N_O[11] == !$past(DIR_I[11]))
		&& (PAD_O[11] == $past(GPIO_OUT_I[11])))
		else $error("pin 11 reserved code not gpio");

	a_pin9_tx: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[19:18] == 2'b10) |=> (PAD_O[9] == $past(SERIAL_OUT_I.tx0)) && !PAD_OE_N_O[9])
		else $error("pin 9 transmit output wrong");

	a_pin7_compare: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[15:14] == 2'b10) |=> (PAD_O[7] == $past(TIMER_OUT_I.cmp_xb)) && !PAD_OE_N_O[7])
		else $error("pin 7 compare output wrong");

	a_pin6_tclk: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[13:12] == 2'b01) |=> PAD_OE_N_O[6] && (TIMER_IN_O.ext_clk_c == $past(pad_sync[6])))
		else $error("pin 6 timer clock input wrong");

	// pins 5 to 2 as capture compare pins
	a_pin5_capture: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[11:10] == 2'b10) && !DIR_I[5] |=> PAD_OE_N_O[5]
		&& (TIMER_IN_O.capcomp[5] == $past(pad_sync[5])))
		else $error("pin 5 capture input wrong");

	a_pin3_capcomp: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[7:6] == 2'b10) |=> (PAD_OE_N_O[3] == !$past(DIR_I[3]))
		&& (PAD_O[3] == $past(TIMER_OUT_I.capcomp[3])))
		else $error("pin 3 capture compare wrong");

	a_pin2_capture: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(func_sel[5:4] == 2'b10) |=> (TIMER_IN_O.capcomp[2] == $past(pad_sync[2])))
		else $error("pin 2 capture input wrong");

	// deselected peripheral inputs rest at their idle levels
	a_irq_idle: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		ARST_N_I && (func_sel[31:30] != 2'b01) |=> EXT_INT_REQ_O[3])
		else $error("deselected interrupt input not idle");

	a_capcomp_idle: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		ARST_N_I && (func_sel[1:0] != 2'b10) |=> !TIMER_IN_O.capcomp[0])
		else $error("deselected capture input not idle");

	// register port: read data stands one cycle, zero otherwise
	a_read_high: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		RD_I && hit_high |=> (RD_DATA_O == $past(func_high)))
		else $error("upper register read wrong");

	a_read_low: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		RD_I && hit_low |=> (RD_DATA_O == $past(func_low)))
		else $error("lower register read wrong");

	a_read_idle: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		!RD_I |=> (RD_DATA_O == pbf_pkg::PBF_READ_IDLE))
		else $error("read data not zero outside a read");

	a_high_no_low: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		(WR_I && hit_high) |=> $stable(func_low) && (func_high == $past(WR_DATA_I)))
		else $error("upper write disturbed lower register");

	// power-on reset clears both registers and releases every pad
	a_reset_clears: assert property (@(posedge CLOCK_I)
		!ARST_N_I |=> (func_sel == 32'h00000000) && (PAD_OE_N_O == 16'hffff))
		else $error("power-on reset left a register or pad set");

	// pad levels reach the pin status three edges later
	a_pad_sync_delay: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
		ARST_N_I [*3] |=> (GPIO_IN_O == $past(PAD_I, 3)))
		else $error("pad input path latency wrong");

endmodule : pbf_port_b_func_sel
`default_nettype wire

// ---- pbf_pkg.sv ----
// package: register map, pin mode codes and carriers for the port b function selector
`default_nettype none
package pbf_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] PBF_ADDR_HIGH = 4'h0;
	localparam logic [3:0] PBF_ADDR_LOW = 4'h2;
	// value after power-on reset, all pins general i/o
	localparam logic [15:0] PBF_RESET_VALUE = 16'h0000;
	// all-zero read value for unmapped offsets and idle cycles
	localparam logic [15:0] PBF_READ_IDLE = 16'h0000;
	// pin count of the port
	localparam int PBF_PINS = 16;
	// 2-bit mode code of one pin
	typedef enum logic [1:0] {
		PBF_MODE_GPIO = 2'b00,
		PBF_MODE_ALT1 = 2'b01,
		PBF_MODE_ALT2 = 2'b10,
		PBF_MODE_PATTERN = 2'b11
	} pbf_mode_type;
	// pins where code 01 is a real function (interrupts, timer clocks)
	localparam logic [15:0] PBF_ALT1_VALID = 16'hf0c0;
	// pins where code 10 is a real function
	localparam logic [15:0] PBF_ALT2_VALID = 16'h3fff;
	// code 10 functions that always drive the pin
	localparam logic [15:0] PBF_ALT2_DRIVE = 16'h0ac0;
	// code 10 functions whose direction follows the direction bit
	localparam logic [15:0] PBF_ALT2_DIR = 16'h303f;
	// level seen by a peripheral input while its pin is not selected
	localparam logic [15:0] PBF_IDLE_ALT1 = 16'hf000;
	localparam logic [15:0] PBF_IDLE_ALT2 = 16'h3500;
	// outputs of the timer unit toward the pins
	typedef struct packed {
		logic cmp_xb;
		logic cmp_xa;
		logic [5:0] capcomp;
	} pbf_timer_out_type;
	// inputs of the timer unit from the pins
	typedef struct packed {
		logic ext_clk_d;
		logic ext_clk_c;
		logic [5:0] capcomp;
	} pbf_timer_in_type;
	// serial channel outputs toward the pins
	typedef struct packed {
		logic clk1;
		logic clk0;
		logic tx1;
		logic tx0;
	} pbf_serial_out_type;
	// serial channel inputs from the pins
	typedef struct packed {
		logic clk1;
		logic clk0;
		logic rx1;
		logic rx0;
	} pbf_serial_in_type;
endpackage : pbf_pkg
`default_nettype wire

// ---- pbf_board_model.sv ----
// board side of port b: pads resolved from the selector's drive enables
`timescale 1ns/1ns
`default_nettype none
module pbf_board_model (
	// pad side of the selector
	input wire logic [15:0] pad_o_i,
	input wire logic [15:0] pad_oe_n_i,
	// level the board itself puts on a pad that the chip leaves alone
	input wire logic [15:0] ext_i,
	// level seen at the pad inputs
	output logic [15:0] pad_i_o
);
	// a driven pad reads back its own level, a released one the board level
	assign pad_i_o = (pad_o_i & ~pad_oe_n_i) | (ext_i & pad_oe_n_i);
endmodule : pbf_board_model
`default_nettype wire

// ---- pbf_port_b_func_sel_test.sv ----
// self-checking bench for the port b function selector
`timescale 1ns/1ns
`default_nettype none
module pbf_port_b_func_sel_test;
	// clock, reset and register port
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	// neighbour registers, board level and peripheral sources
	logic [15:0] dir = 16'h0000;
	logic [15:0] gpio_out = 16'h96c3;
	logic [15:0] pattern = 16'h5ac3;
	logic [15:0] ext = 16'h9a6c;
	pbf_pkg::pbf_timer_out_type tmr_out = 8'h6b;
	pbf_pkg::pbf_serial_out_type ser_out = 4'h9;
	// pad and peripheral observations
	logic [15:0] gpio_in, pad_o, pad_oe_n, pad_i;
	logic [3:0] irq;
	pbf_pkg::pbf_timer_in_type tmr_in;
	pbf_pkg::pbf_serial_in_type ser_in;
	// counters of the run
	int miscompares = 0;
	int samples_checked = 0;

	// clock at 250 MHz
	initial begin
		forever #2 clk = ~clk;
	end

	pbf_port_b_func_sel dut (.CLOCK_I(clk), .ARST_N_I(arst_n), .WR_I(wr), .RD_I(rd), .ADDR_I(addr),
		.WR_DATA_I(wdata), .RD_DATA_O(rdata), .DIR_I(dir), .GPIO_OUT_I(gpio_out), .GPIO_IN_O(gpio_in),
		.PAD_I(pad_i), .PAD_O(pad_o), .PAD_OE_N_O(pad_oe_n), .PATTERN_I(pattern), .TIMER_OUT_I(tmr_out),
		.SERIAL_OUT_I(ser_out), .EXT_INT_REQ_O(irq), .TIMER_IN_O(tmr_in), .SERIAL_IN_O(ser_in));

	pbf_board_model board (.pad_o_i(pad_o), .pad_oe_n_i(pad_oe_n), .ext_i(ext), .pad_i_o(pad_i));

	// compare one value, count it and report a mismatch
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// verdict and end of run
	task final_report;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	// one write cycle, then one idle cycle
	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg

	// one read cycle; data in the next cycle only, zero after
	task rd_reg(input logic [3:0] a, input logic [15:0] exp);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check(rdata, exp);
		@(negedge clk);
		check(rdata, 16'h0000);
		@(posedge clk);
	endtask : rd_reg

	// expected {drive, level} of pin p under mode c and direction d
	function automatic logic [1:0] exp_pin(input int p, input logic [1:0] c, input logic d);
		case (c)
			2'b11: return {1'b1, pattern[p]};
			2'b01: return (p >= 12 || p == 7 || p == 6) ? 2'b00 : {d, gpio_out[p]};
			2'b10: begin
				if (p >= 14) return {d, gpio_out[p]};
				if (p == 13) return {d, ser_out.clk1};
				if (p == 12) return {d, ser_out.clk0};
				if (p == 11) return {1'b1, ser_out.tx1};
				if (p == 9) return {1'b1, ser_out.tx0};
				if (p == 10 || p == 8) return 2'b00;
				return {p >= 6 || d, tmr_out[p]};
			end
			default: return {d, gpio_out[p]};
		endcase
	endfunction : exp_pin

	// program both registers, then check pads, inputs and read-back
	task run_mode(input logic [15:0] hi, input logic [15:0] lo, input logic [15:0] dm);
		logic [1:0] c;
		logic [1:0] e;
		logic [15:0] drv, val, lvl;
		logic [3:0] xi, si;
		logic [7:0] ti;
		wr_reg(pbf_pkg::PBF_ADDR_HIGH, hi);
		wr_reg(pbf_pkg::PBF_ADDR_LOW, lo);
		dir <= dm;
		repeat (5) @(posedge clk);
		xi = 4'hf;
		si = 4'hf;
		ti = 8'h00;
		for (int p = 0; p < 16; p++) begin
			c = (p >= 8) ? hi[2*p-16 +: 2] : lo[2*p +: 2];
			e = exp_pin(p, c, dm[p]);
			drv[p] = e[1];
			val[p] = e[0];
			lvl[p] = e[1] ? e[0] : ext[p];
			if (c == 2'b01 && p >= 12) xi[p-12] = lvl[p];
			if (c == 2'b01 && (p == 7 || p == 6)) ti[p] = lvl[p];
			if (c == 2'b10 && p <= 5) ti[p] = lvl[p];
			if (c == 2'b10 && (p == 13 || p == 12)) si[p-10] = lvl[p];
			if (c == 2'b10 && (p == 10 || p == 8)) si[p/2-4] = lvl[p];
		end
		@(negedge clk);
		check(pad_oe_n, ~drv);
		check(pad_o & drv, val & drv);
		check(gpio_in, lvl);
		check({12'h000, irq}, {12'h000, xi});
		check({8'h00, tmr_in}, {8'h00, ti});
		check({12'h000, ser_in}, {12'h000, si});
		@(posedge clk);
		rd_reg(pbf_pkg::PBF_ADDR_HIGH, hi);
		rd_reg(pbf_pkg::PBF_ADDR_LOW, lo);
	endtask : run_mode

	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd_reg(pbf_pkg::PBF_ADDR_HIGH, 16'h0000);
		rd_reg(pbf_pkg::PBF_ADDR_LOW, 16'h0000);
		run_mode(16'h0000, 16'h0000, 16'h0000);
		run_mode(16'h0000, 16'h0000, 16'hffff);
		run_mode(16'h5555, 16'h5555, 16'h0000);
		run_mode(16'h5555, 16'h5555, 16'hffff);
		run_mode(16'haaaa, 16'haaaa, 16'h0000);
		run_mode(16'haaaa, 16'haaaa, 16'hffff);
		run_mode(16'hffff, 16'hffff, 16'h0000);
		// second source set: every alternate source except pins 2 and 7 now differs from the data register
		gpio_out <= 16'h693c;
		ext <= 16'h6593;
		ser_out <= 4'h5;
		tmr_out <= 8'h47;
		run_mode(16'hffff, 16'hffff, 16'h0000);
		run_mode(16'h5555, 16'h5555, 16'h0000);
		run_mode(16'haaaa, 16'haaaa, 16'hffff);
		run_mode(16'haaaa, 16'haaaa, 16'h0000);
		run_mode(16'h1be4, 16'h6c93, 16'h3c5a);
		// unmapped offsets: write ignored, read zero
		wr_reg(4'h1, 16'hffff);
		rd_reg(4'h4, 16'h0000);
		rd_reg(pbf_pkg::PBF_ADDR_HIGH, 16'h1be4);
		rd_reg(pbf_pkg::PBF_ADDR_LOW, 16'h6c93);
		// write then read back to back, no gap between the strobes
		wr <= 1'b1;
		addr <= pbf_pkg::PBF_ADDR_HIGH;
		wdata <= 16'h3c96;
		@(posedge clk);
		wr <= 1'b0;
		rd_reg(pbf_pkg::PBF_ADDR_HIGH, 16'h3c96);
		// second power-on reset in mid-run
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd_reg(pbf_pkg::PBF_ADDR_HIGH, 16'h0000);
		rd_reg(pbf_pkg::PBF_ADDR_LOW, 16'h0000);
		final_report;
	end

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		final_report;
	end
endmodule : pbf_port_b_func_sel_test
`default_nettype wire
